/* File: hdl/paff_pkg.sv */
package paff_pkg;
   localparam logic [7:0] CMD_ALERT_A = 8'h02;
   localparam logic [7:0] CMD_FAULT_A = 8'h03;
   localparam logic [7:0] CMD_ALERT_B = 8'h04;
   localparam logic [7:0] CMD_FAULT_B = 8'h05;
   localparam int SUMMARY_ALERT_BIT = 13;
   localparam int SUMMARY_FAULT_BIT = 12;
   localparam int LOCKOUT_BIT = 1;
   localparam int REGULATOR_BIT = 0;
   localparam int RESERVED_B_BIT = 2;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam int LATCH_CNT_W = 4;

   // voltage/current sources, msb first as laid out in register A bits 7..2
   typedef struct packed {
      logic cell_overvoltage_flag;
      logic cell_undervoltage_flag;
      logic discharge_short_flag;
      logic discharge_overcurrent_tier1_flag;
      logic discharge_overcurrent_tier2_flag;
      logic charge_overcurrent_flag;
   } paff_src_a_t;

   // temperature/diagnostic sources, register B bits 7..3 then 1..0
   typedef struct packed {
      logic discharge_overtemp_flag;
      logic charge_overtemp_flag;
      logic discharge_undertemp_flag;
      logic charge_undertemp_flag;
      logic internal_overtemp_flag;
      logic reference_diag_flag;
      logic ground_diag_flag;
   } paff_src_b_t;

   // read answer to the command port
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } paff_rd_t;
endpackage : paff_pkg

/* File: hdl/paff_lockout.sv */
`timescale 1ns/10ps
`default_nettype none
module paff_lockout #(
   parameter int CNT_W = paff_pkg::LATCH_CNT_W
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // recovery bookkeeping
   input wire logic recovery_attempt_in,
   input wire logic lockout_clear_in,
   input wire logic [CNT_W-1:0] latch_count_in,
   // status
   output logic current_recovery_lockout_flag_out,
   output logic timed_recovery_enable_out
);
   logic [CNT_W:0] attempts_reg;
   logic [CNT_W:0] attempts_next;
   logic lockout_reg;

   generate
      if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
         $error("paff_lockout: CNT_W out of range");
      end
   endgenerate

   // one extra bit so count can pass the largest latch count; saturates
   always_comb begin
      attempts_next = attempts_reg;
      if (lockout_clear_in) begin
         attempts_next = '0;
      end
      // attempt in the clearing cycle still counts
      if (recovery_attempt_in && attempts_next != {(CNT_W+1){1'b1}}) begin
         attempts_next = attempts_next + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         attempts_reg <= '0;
      end else begin
         attempts_reg <= attempts_next;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lockout_reg <= 1'b0;
      end else begin
         lockout_reg <= attempts_next > {1'b0, latch_count_in};
      end
   end

   assign current_recovery_lockout_flag_out = lockout_reg;
   assign timed_recovery_enable_out = !lockout_reg;

   chk_lockout_on_exceed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (attempts_reg > {1'b0, latch_count_in}) |-> lockout_reg)
      else $error("lockout not set after count exceeded");
   chk_lockout_clear_below: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (attempts_reg <= {1'b0, latch_count_in}) && $stable(latch_count_in) |-> !lockout_reg)
      else $error("lockout set before count exceeded");
endmodule : paff_lockout
`default_nettype wire

/* File: hdl/paff_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module paff_flags #(
   parameter int CNT_W = paff_pkg::LATCH_CNT_W
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // raw triggers from protection evaluation
   input wire paff_pkg::paff_src_a_t alert_src_a_in,
   input wire paff_pkg::paff_src_a_t fault_src_a_in,
   input wire logic regulator_output_fault_flag_in,
   input wire paff_pkg::paff_src_b_t alert_src_b_in,
   input wire paff_pkg::paff_src_b_t fault_src_b_in,
   // per-bit enables, register layout
   input wire logic [7:0] alert_enable_a_in,
   input wire logic [7:0] fault_enable_a_in,
   input wire logic [7:0] alert_enable_b_in,
   input wire logic [7:0] fault_enable_b_in,
   // current recovery
   input wire logic recovery_attempt_in,
   input wire logic lockout_clear_in,
   input wire logic [CNT_W-1:0] latch_count_in,
   output logic timed_recovery_enable_out,
   // command port
   input wire logic [7:0] cmd_code_in,
   input wire logic rd_req_in,
   input wire logic wr_req_in,
   output paff_pkg::paff_rd_t rd_out,
   output logic wr_ignored_out,
   // flag registers and summary
   output logic [7:0] protection_alert_flags_a_out,
   output logic [7:0] protection_fault_flags_a_out,
   output logic [7:0] protection_alert_flags_b_out,
   output logic [7:0] protection_fault_flags_b_out,
   output logic [15:0] summary_status_out
);
   logic [7:0] protection_alert_flags_a_reg;
   logic [7:0] protection_fault_flags_a_reg;
   logic [7:0] protection_alert_flags_b_reg;
   logic [7:0] protection_fault_flags_b_reg;
   logic [7:0] alert_a_next;
   logic [7:0] fault_a_next;
   logic [7:0] alert_b_next;
   logic [7:0] fault_b_next;
   logic alert_present_summary_reg;
   logic fault_present_summary_reg;
   paff_pkg::paff_rd_t rd_reg;
   logic wr_ignored_reg;
   logic lockout_flag;

   generate
      if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
         $error("paff_flags: CNT_W out of range");
      end
   endgenerate

   function automatic logic is_flag_cmd(input logic [7:0] code);
      is_flag_cmd = code >= paff_pkg::CMD_ALERT_A && code <= paff_pkg::CMD_FAULT_B;
   endfunction : is_flag_cmd

   // B layout leaves bit 2 as a zero hole
   function automatic logic [7:0] place_b(input paff_pkg::paff_src_b_t src);
      place_b = {src[6:2], 1'b0, src[1:0]};
   endfunction : place_b

   paff_lockout #(
      .CNT_W(CNT_W)
   ) u_paff_lockout (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .recovery_attempt_in(recovery_attempt_in),
      .lockout_clear_in(lockout_clear_in),
      .latch_count_in(latch_count_in),
      .current_recovery_lockout_flag_out(lockout_flag),
      .timed_recovery_enable_out(timed_recovery_enable_out)
   );

   // flags follow triggers gated by enables; reserved bits forced low
   always_comb begin
      alert_a_next = {alert_src_a_in, 2'b00} & alert_enable_a_in;
      fault_a_next = {fault_src_a_in, lockout_flag, regulator_output_fault_flag_in}
         & fault_enable_a_in;
      alert_b_next = place_b(alert_src_b_in) & alert_enable_b_in;
      fault_b_next = place_b(fault_src_b_in) & fault_enable_b_in;
   end

   // only the evaluation side loads these; host writes never reach them
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         protection_alert_flags_a_reg <= paff_pkg::FLAGS_RESET;
         protection_fault_flags_a_reg <= paff_pkg::FLAGS_RESET;
         protection_alert_flags_b_reg <= paff_pkg::FLAGS_RESET;
         protection_fault_flags_b_reg <= paff_pkg::FLAGS_RESET;
      end else begin
         protection_alert_flags_a_reg <= alert_a_next;
         protection_fault_flags_a_reg <= fault_a_next;
         protection_alert_flags_b_reg <= alert_b_next;
         protection_fault_flags_b_reg <= fault_b_next;
      end
   end

   // summary computed from next values so it lines up with the registers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         alert_present_summary_reg <= 1'b0;
         fault_present_summary_reg <= 1'b0;
      end else begin
         alert_present_summary_reg <= |{alert_a_next, alert_b_next};
         fault_present_summary_reg <= |{fault_a_next, fault_b_next};
      end
   end

   // reads have no security gating; unmapped codes answer zero
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_reg <= '0;
      end else begin
         rd_reg.valid <= rd_req_in;
         if (rd_req_in) begin
            case (cmd_code_in)
               paff_pkg::CMD_ALERT_A: rd_reg.data <= protection_alert_flags_a_reg;
               paff_pkg::CMD_FAULT_A: rd_reg.data <= protection_fault_flags_a_reg;
               paff_pkg::CMD_ALERT_B: rd_reg.data <= protection_alert_flags_b_reg;
               paff_pkg::CMD_FAULT_B: rd_reg.data <= protection_fault_flags_b_reg;
               default: rd_reg.data <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ignored_reg <= 1'b0;
      end else begin
         wr_ignored_reg <= wr_req_in && is_flag_cmd(cmd_code_in);
      end
   end

   assign protection_alert_flags_a_out = protection_alert_flags_a_reg;
   assign protection_fault_flags_a_out = protection_fault_flags_a_reg;
   assign protection_alert_flags_b_out = protection_alert_flags_b_reg;
   assign protection_fault_flags_b_out = protection_fault_flags_b_reg;
   assign rd_out = rd_reg;
   assign wr_ignored_out = wr_ignored_reg;
   assign summary_status_out = {2'b00, alert_present_summary_reg, fault_present_summary_reg, 12'h000};

   sequence s_read_a_req;
      rd_req_in && cmd_code_in == paff_pkg::CMD_ALERT_A;
   endsequence
   sequence s_read_a_ans;
      rd_out.valid && rd_out.data == $past(protection_alert_flags_a_reg);
   endsequence
   sequence s_read_other_req;
      rd_req_in && !is_flag_cmd(cmd_code_in);
   endsequence
   sequence s_read_zero_ans;
      rd_out.valid && rd_out.data == 8'h00;
   endsequence

   chk_alert_a_reserved: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      protection_alert_flags_a_reg[1:0] == 2'b00)
      else $error("alert A reserved bits set");
   chk_alert_a_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> protection_alert_flags_a_reg[7:2] == $past(alert_src_a_in & alert_enable_a_in[7:2]))
      else $error("alert A not tracking enabled triggers");
   chk_fault_a_lockout: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> protection_fault_flags_a_reg[paff_pkg::LOCKOUT_BIT]
         == $past(lockout_flag && fault_enable_a_in[paff_pkg::LOCKOUT_BIT]))
      else $error("lockout bit misplaced");
   chk_fault_a_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> protection_fault_flags_a_reg[7:2] == $past(fault_src_a_in & fault_enable_a_in[7:2]))
      else $error("fault A not tracking enabled triggers");
   chk_b_reserved: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !protection_alert_flags_b_reg[paff_pkg::RESERVED_B_BIT]
         && !protection_fault_flags_b_reg[paff_pkg::RESERVED_B_BIT])
      else $error("B reserved bit set");
   chk_fault_b_ground: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      fault_src_b_in.ground_diag_flag && fault_enable_b_in[0] |=> protection_fault_flags_b_reg[0])
      else $error("ground fault not reported at bit 0");
   chk_read_alert_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      s_read_a_req |=> s_read_a_ans)
      else $error("read of alert A wrong");
   chk_summary_alert: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      summary_status_out[paff_pkg::SUMMARY_ALERT_BIT]
         == |{protection_alert_flags_a_reg, protection_alert_flags_b_reg})
      else $error("alert summary disagrees with flags");
   chk_write_no_effect: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wr_req_in && is_flag_cmd(cmd_code_in) |=> wr_ignored_out
         && protection_alert_flags_a_reg == $past(alert_a_next))
      else $error("write disturbed flags");
   chk_fault_a_regulator: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> protection_fault_flags_a_reg[paff_pkg::REGULATOR_BIT]
         == $past(regulator_output_fault_flag_in && fault_enable_a_in[paff_pkg::REGULATOR_BIT]))
      else $error("regulator fault bit misplaced");
   chk_alert_b_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> protection_alert_flags_b_reg[7:3] == $past(alert_src_b_in[6:2] & alert_enable_b_in[7:3])
         && protection_alert_flags_b_reg[1:0] == $past(alert_src_b_in[1:0] & alert_enable_b_in[1:0]))
      else $error("alert B not tracking enabled triggers");
   chk_fault_b_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> protection_fault_flags_b_reg[7:3] == $past(fault_src_b_in[6:2] & fault_enable_b_in[7:3])
         && protection_fault_flags_b_reg[1:0] == $past(fault_src_b_in[1:0] & fault_enable_b_in[1:0]))
      else $error("fault B not tracking enabled triggers");
   chk_summary_fault: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      summary_status_out[paff_pkg::SUMMARY_FAULT_BIT]
         == |{protection_fault_flags_a_reg, protection_fault_flags_b_reg})
      else $error("fault summary disagrees with flags");
   // answer carries the value held at the taking edge
   chk_read_fault_b: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      rd_req_in && cmd_code_in == paff_pkg::CMD_FAULT_B
         |=> rd_out.valid && rd_out.data == $past(protection_fault_flags_b_reg))
      else $error("read of fault B wrong");
   chk_read_unmapped: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      s_read_other_req |=> s_read_zero_ans)
      else $error("unmapped read not answered with zero");
   chk_read_valid_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !rd_req_in |=> !rd_out.valid)
      else $error("read valid without request");
   chk_write_other: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !(wr_req_in && is_flag_cmd(cmd_code_in)) |=> !wr_ignored_out)
      else $error("write ignore flagged without flag write");
endmodule : paff_flags
`default_nettype wire

/* File: verif/paff_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module paff_host_model (
   // clock
   input wire logic sys_clk_in,
   // command port
   output logic [7:0] cmd_code_out,
   output logic rd_req_out,
   output logic wr_req_out,
   input wire paff_pkg::paff_rd_t rd_in,
   input wire logic wr_ignored_in
);
   initial begin
      cmd_code_out = 8'h00;
      rd_req_out = 1'b0;
      wr_req_out = 1'b0;
   end

   // one request per call, answer taken one cycle later
   task automatic access(input logic [7:0] code, input logic wr, output paff_pkg::paff_rd_t rsp, output logic ign);
      @(negedge sys_clk_in);
      cmd_code_out = code;
      rd_req_out = !wr;
      wr_req_out = wr;
      @(negedge sys_clk_in);
      rsp = rd_in;
      ign = wr_ignored_in;
      rd_req_out = 1'b0;
      wr_req_out = 1'b0;
      // released code lines must not keep the last value
      cmd_code_out = ~code;
   endtask : access
endmodule : paff_host_model
`default_nettype wire

/* File: verif/paff_flags_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module paff_flags_tb_top;
   int err_total = 0;
   int n_checks = 0;
   logic clk = 1'b0;
   logic rst = 1'b1;
   paff_pkg::paff_src_a_t asa = '0, fsa = '0;
   paff_pkg::paff_src_b_t asb = '0, fsb = '0;
   logic reg_f = 1'b0, att = 1'b0, clr = 1'b0, tre, rdq, wrq, wri;
   logic [3:0] lc = 4'h0;
   logic [7:0] en_aa = 8'h00, en_fa = 8'h00, en_ab = 8'h00, en_fb = 8'h00, cmd, ra, qa, rb, qb;
   logic [15:0] sum;
   paff_pkg::paff_rd_t rd;

   paff_flags #(.CNT_W(4)) u_paff_flags (
      .sys_clk_in(clk), .rst_in(rst), .alert_src_a_in(asa), .fault_src_a_in(fsa),
      .regulator_output_fault_flag_in(reg_f), .alert_src_b_in(asb), .fault_src_b_in(fsb),
      .alert_enable_a_in(en_aa), .fault_enable_a_in(en_fa), .alert_enable_b_in(en_ab), .fault_enable_b_in(en_fb),
      .recovery_attempt_in(att), .lockout_clear_in(clr), .latch_count_in(lc), .timed_recovery_enable_out(tre),
      .cmd_code_in(cmd), .rd_req_in(rdq), .wr_req_in(wrq), .rd_out(rd), .wr_ignored_out(wri),
      .protection_alert_flags_a_out(ra), .protection_fault_flags_a_out(qa), .protection_alert_flags_b_out(rb),
      .protection_fault_flags_b_out(qb), .summary_status_out(sum));
   paff_host_model u_paff_host_model (.sys_clk_in(clk), .cmd_code_out(cmd), .rd_req_out(rdq), .wr_req_out(wrq),
      .rd_in(rd), .wr_ignored_in(wri));

   always #50 clk = ~clk;

   task automatic t_map_a;
      en_aa = 8'hff;
      en_fa = 8'hff;
      for (int i = 0; i < 6; i++) begin
         asa = 6'h20 >> i;
         fsa = 6'h20 >> i;
         @(negedge clk);
         `CHK(ra, 8'h80 >> i)
         `CHK(qa, 8'h80 >> i)
         `CHK(sum, 16'h3000)
      end
      asa = 6'h3f;
      fsa = 6'h3f;
      reg_f = 1'b1;
      en_aa = 8'h7f;
      en_fa = 8'hfe;
      @(negedge clk);
      `CHK(ra, 8'h7c)
      `CHK(qa, 8'hfc)
      en_aa = 8'hff;
      en_fa = 8'hff;
      @(negedge clk);
      `CHK(ra, 8'hfc)
      `CHK(qa, 8'hfd)
      $display("test map_a done");
   endtask : t_map_a

   task automatic t_map_b;
      asa = '0;
      fsa = '0;
      reg_f = 1'b0;
      en_ab = 8'hff;
      en_fb = 8'hff;
      for (int i = 0; i < 7; i++) begin
         asb = 7'h40 >> i;
         fsb = 7'h00;
         @(negedge clk);
         `CHK(rb, (i < 5) ? 8'h80 >> i : 8'h02 >> (i - 5))
         `CHK(sum, 16'h2000)
         fsb = asb;
         asb = 7'h00;
         @(negedge clk);
         `CHK(qb, (i < 5) ? 8'h80 >> i : 8'h02 >> (i - 5))
         `CHK(sum, 16'h1000)
      end
      asb = 7'h7f;
      fsb = 7'h7f;
      @(negedge clk);
      `CHK({rb, qb}, 16'hfbfb)
      en_ab = 8'h00;
      en_fb = 8'h00;
      @(negedge clk);
      `CHK({rb, qb, sum}, 32'h0)
      $display("test map_b done");
   endtask : t_map_b

   task automatic t_lockout;
      en_fa = 8'h02;
      lc = 4'h2;
      for (int i = 0; i < 3; i++) begin
         att = 1'b1;
         @(negedge clk);
         att = 1'b0;
         `CHK(qa, 8'h00)
         @(negedge clk);
      end
      `CHK({qa, tre, sum}, 25'h004_1000)
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({qa, tre}, 9'h001)
      $display("test lockout done");
   endtask : t_lockout

   task automatic t_cmd;
      paff_pkg::paff_rd_t rsp;
      logic ign;
      logic [7:0] exp_v [4] = '{8'h80, 8'h04, 8'h80, 8'h01};
      asa = 6'h20;
      fsa = 6'h01;
      asb = 7'h40;
      fsb = 7'h01;
      en_fa = 8'hff;
      en_ab = 8'hff;
      en_fb = 8'hff;
      for (int i = 0; i < 4; i++) begin
         u_paff_host_model.access(8'h02 + 8'(i), 1'b0, rsp, ign);
         `CHK(rsp, {1'b1, exp_v[i]})
         u_paff_host_model.access(8'h02 + 8'(i), 1'b1, rsp, ign);
         `CHK(ign, 1'b1)
      end
      u_paff_host_model.access(8'h06, 1'b1, rsp, ign);
      `CHK(ign, 1'b0)
      u_paff_host_model.access(8'h06, 1'b0, rsp, ign);
      `CHK(rsp, 9'h100)
      `CHK({ra, qa, rb, qb}, 32'h8004_8001)
      $display("test cmd done");
   endtask : t_cmd

   // lockout set, then reset in mid-run must drop it and restore timed recovery
   task automatic t_reset_mid;
      lc = 4'h0;
      att = 1'b1;
      @(negedge clk);
      att = 1'b0;
      @(negedge clk);
      `CHK({qa, tre}, 9'h00c)
      rst = 1'b1;
      @(negedge clk);
      `CHK({ra, qa, rb, qb, sum, tre}, 49'h1)
      rst = 1'b0;
      @(negedge clk);
      `CHK({ra, qa, rb, qb, sum}, 48'h8004_8001_3000)
      `CHK(tre, 1'b1)
      $display("test reset_mid done");
   endtask : t_reset_mid

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(negedge clk);
      `CHK({ra, qa, rb, qb, sum, rd, wri, tre}, 59'h1)
      rst = 1'b0;
      t_map_a();
      t_map_b();
      t_lockout();
      t_cmd();
      t_reset_mid();
      final_report();
   end

   // tests need about 63 cycles; the 1200-cycle limit is about nineteen times that
   initial begin
      #120_000;
      err_total++;
      final_report();
   end
endmodule : paff_flags_tb_top
`default_nettype wire
